// [pkg/uicr_map.vh]
`ifndef UICR_MAP_VH
`define UICR_MAP_VH

// register offsets within one serial port window
`define UICR_OFS_MASK 12'h030
`define UICR_OFS_RAW 12'h03C
`define UICR_OFS_MIS 12'h040
`define UICR_OFS_CLR 12'h044
`define UICR_OFS_SET 12'h048
`define UICR_OFS_ID4 12'hFD0
`define UICR_OFS_ID5 12'hFD4
`define UICR_OFS_ID6 12'hFD8

// instance bases
`define UICR_BASE0 32'h4000C000
`define UICR_BASE1 32'h4000D000
`define UICR_BASE_MASK 32'hFFFFF000

// interrupt bit positions
`define UICR_BIT_RX 4
`define UICR_BIT_TX 5
`define UICR_BIT_RT 6
`define UICR_BIT_FE 7
`define UICR_IRQ_W 4
`define UICR_IRQ_LSB 4

// reset values
`define UICR_RST_MASK 4'h0
`define UICR_RST_RAW 4'h0

// identifier bytes, arbitrary neutral values
`define UICR_ID_31_0 32'h5A3C6E21
`define UICR_ID_BYTE4 8'h4B

`endif

// [rtl/uicr_decode.v]
`include "uicr_map.vh"

module uicr_decode (
	// address
	input wire [31:0] addr,
	// decode
	output reg hit,
	output reg inst,
	output reg [11:0] ofs
);

	// instance select
	always @* begin
		ofs = addr[11:0];
		hit = 1'b0;
		inst = 1'b0;
		if ((addr & `UICR_BASE_MASK) == `UICR_BASE0) begin
			hit = 1'b1;
		end else if ((addr & `UICR_BASE_MASK) == `UICR_BASE1) begin
			hit = 1'b1;
			inst = 1'b1;
		end
	end

endmodule // uicr_decode

// [rtl/uicr_irq_bank.v]
`include "uicr_map.vh"

module uicr_irq_bank (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// events and controls
	input wire [3:0] evt,
	input wire clrWr,
	input wire setWr,
	input wire maskWr,
	input wire [3:0] wdata,
	// state
	output reg [3:0] raw,
	output reg [3:0] mask
);

	reg [3:0] next_raw;

	// set wins over clear; zero bits leave state alone
	always @* begin
		next_raw = raw;
		if (clrWr) begin
			next_raw = raw & ~wdata;
		end
		if (setWr) begin
			next_raw = next_raw | wdata;
		end
		next_raw = next_raw | evt;
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			raw <= `UICR_RST_RAW;
			mask <= `UICR_RST_MASK;
		end else begin
			raw <= next_raw;
			if (maskWr) begin
				mask <= wdata;
			end
		end
	end

endmodule // uicr_irq_bank

// [rtl/uicr_regs.v]
// The plain strobed port was decided locally.
`include "uicr_map.vh"

module uicr_regs (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// register port
	input wire [31:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	// interrupt events, bits fe rt tx rx, one per instance
	input wire [3:0] evt0,
	input wire [3:0] evt1,
	// masked status per instance
	output reg [3:0] mis0,
	output reg [3:0] mis1
);

	wire hit;
	wire inst;
	wire [11:0] ofs;
	wire [3:0] raw0;
	wire [3:0] raw1;
	wire [3:0] mask0;
	wire [3:0] mask1;
	wire [3:0] wfield;
	reg [31:0] next_rdata;
	reg [3:0] selRaw;
	reg [3:0] selMask;

	localparam [31:0] ID_WORD = `UICR_ID_31_0;

	assign wfield = wdata[`UICR_BIT_FE:`UICR_IRQ_LSB];

	// place a 4-bit field at bits 7:4
	function [31:0] field;
		input [3:0] f;
		begin
			field = {24'h000000, f, 4'h0};
		end
	endfunction

	function isWr;
		input w;
		input h;
		input i;
		input want;
		input [11:0] o;
		input [11:0] target;
		begin
			isWr = w & h & (i == want) & (o == target);
		end
	endfunction

	uicr_decode uDec (
		.addr(addr),
		.hit(hit),
		.inst(inst),
		.ofs(ofs)
	);

	uicr_irq_bank uBank0 (
		.mclk(mclk),
		.rst_n(rst_n),
		.evt(evt0),
		.clrWr(isWr(wr, hit, inst, 1'b0, ofs, `UICR_OFS_CLR)),
		.setWr(isWr(wr, hit, inst, 1'b0, ofs, `UICR_OFS_SET)),
		.maskWr(isWr(wr, hit, inst, 1'b0, ofs, `UICR_OFS_MASK)),
		.wdata(wfield),
		.raw(raw0),
		.mask(mask0)
	);

	uicr_irq_bank uBank1 (
		.mclk(mclk),
		.rst_n(rst_n),
		.evt(evt1),
		.clrWr(isWr(wr, hit, inst, 1'b1, ofs, `UICR_OFS_CLR)),
		.setWr(isWr(wr, hit, inst, 1'b1, ofs, `UICR_OFS_SET)),
		.maskWr(isWr(wr, hit, inst, 1'b1, ofs, `UICR_OFS_MASK)),
		.wdata(wfield),
		.raw(raw1),
		.mask(mask1)
	);

	// read mux
	always @* begin
		selRaw = inst ? raw1 : raw0;
		selMask = inst ? mask1 : mask0;
		next_rdata = 32'h00000000;
		if (rd && hit) begin
			case (ofs)
			`UICR_OFS_MASK: next_rdata = field(selMask);
			`UICR_OFS_RAW: next_rdata = field(selRaw);
			`UICR_OFS_MIS: next_rdata = field(selRaw & selMask);
			`UICR_OFS_CLR: next_rdata = 32'h00000000;
			`UICR_OFS_ID4: next_rdata = {24'h000000, `UICR_ID_BYTE4};
			`UICR_OFS_ID5: next_rdata = {24'h000000, ID_WORD[15:8]};
			`UICR_OFS_ID6: next_rdata = {24'h000000, ID_WORD[23:16]};
			default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
			mis0 <= 4'h0;
			mis1 <= 4'h0;
		end else begin
			rdata <= next_rdata;
			mis0 <= raw0 & mask0;
			mis1 <= raw1 & mask1;
		end
	end

endmodule // uicr_regs

// [test/uicr_regs_chk.sv]
module uicr_regs_chk(
	input wire mclk,rst_n,wr,rd,
	input wire [31:0] addr,wdata,rdata,
	input wire [3:0] evt0,evt1,mis0,mis1
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [11:0] o=addr[11:0];
	wire b0=addr[31:12]==20'h4000C;
	wire b1=addr[31:12]==20'h4000D;
	wire c0=wr&&b0&&o==12'h044;
	wire c1=wr&&b1&&o==12'h044;
	wire k=c0&&!wdata[7];
	wire r=rd&&(b0||b1);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_ID4: assert property(r&&o==12'hFD0|=>rdata==32'h4B)
		else $error("id4");
	AST_ID5: assert property(r&&o==12'hFD4|=>rdata==32'h6E)
		else $error("id5");
	AST_ID6: assert property(r&&o==12'hFD8|=>rdata==32'h3C)
		else $error("id6");
	AST_CRD: assert property(r&&o==12'h044|=>rdata==32'h0)
		else $error("clear read");
	AST_RT: assert property(c0&&wdata[6]&&!evt0[2]|=>##1 !mis0[2])
		else $error("rt");
	AST_TX: assert property(c0&&wdata[5]&&!evt0[1]|=>##1 !mis0[1])
		else $error("tx");
	AST_RX: assert property(c1&&wdata[4]&&!evt1[0]|=>##1 !mis1[0])
		else $error("rx");
	AST_KEEP: assert property(mis0[3]&&!$past(wr)&&k|=>##1 mis0[3])
		else $error("keep");
	cover property(k&&mis0[3]);
	cover property(c1);
	cover property(r&&o==12'hFD4);
endmodule // uicr_regs_chk
bind uicr_regs uicr_regs_chk chk(.*);

// [test/test_uicr_regs.sv]
module test_uicr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk=0,rst_n=0,wr=0,rd=0;
	logic [31:0] addr=0,wdata=0,rdata,b;
	logic [3:0] evt0=0,evt1=0,mis0,mis1;
	int mismatches=0,checked=0;
	uicr_regs dut(
		.mclk(mclk),
		.rst_n(rst_n),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.evt0(evt0),
		.evt1(evt1),
		.mis0(mis0),
		.mis1(mis1)
	);
	always #2 mclk=~mclk;
	task cmp(input string n,input [31:0] s,e);
		checked++;
		if(s!==e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h",n,e,s);
		end
	endtask
	task wrt(input [31:0] a,d);
		@(posedge mclk) begin addr<=a;wdata<=d;wr<=1;end
		@(posedge mclk) wr<=0;
	endtask
	task rdc(input [31:0] a,e);
		@(posedge mclk) begin addr<=a;rd<=1;end
		@(posedge mclk) rd<=0;
		#1 cmp("rdata",rdata,e);
	endtask
	task results;
		$display("checked %0d mismatches %0d",checked,mismatches);
		if(mismatches==0&&checked>0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#4000;
		mismatches++;
		results;
	end
	initial begin
		repeat(6) @(posedge mclk);
		rst_n<=1;
		wrt(32'h4000CFD4,32'hFF);
		for(int i=0;i<2;i++) begin
			b=32'h4000C000+i*32'h1000;
			rdc(b+12'hFD0,32'h4B);
			rdc(b+12'hFD4,32'h6E);
			rdc(b+12'hFD8,32'h3C);
		end
		rdc(32'h4000EFD4,32'h0);
		@(posedge mclk) begin evt0<=4'hF;evt1<=4'hF;end
		@(posedge mclk) begin evt0<=4'h0;evt1<=4'h0;end
		for(int i=0;i<2;i++) begin
			b=32'h4000C000+i*32'h1000;
			wrt(b+12'h030,32'hF0);
			wrt(b+12'h044,32'h70);
			rdc(b+12'h03C,32'h80);
			rdc(b+12'h040,32'h80);
			rdc(b+12'h044,32'h0);
			rdc(b+12'h030,32'hF0);
		end
		wrt(32'h4000C048,32'h10);
		rdc(32'h4000C03C,32'h90);
		cmp("mis",{mis1,mis0},8'h89);
		results;
	end
endmodule // test_uicr_regs
